// File: rtl/scsel_params.svh
// offsets, field positions, reset values and timing counts of the clock/standby select block
//
// Behaviour
// (RL1) Clock select code 000 runs the bus masters at full speed, and it is the value after reset.
// (RL2) Clock select codes 001 to 101 give a medium-speed clock of the system clock over 2, 4, 8, 16 and 32.
// (RL3) Software never writes clock select codes 110 or 111.
// (RL4) With the transfer speed bit clear in medium-speed mode, all masters including the transfer controller use the medium clock.
// (RL5) With the transfer speed bit set, the transfer controller runs at full speed whenever it has a transfer request, even while the CPU stays slow.
// (RL6) The 3-bit standby wait field sets how long the block waits for the clock to settle when leaving software standby.
// (RL7) With an oscillator, software picks a wait of at least 8 ms.
// (RL8) With an external clock, software picks a wait of at least 500 us.
// (RL9) The bus masters stay stopped during the settling wait and restart only after the full count has elapsed.
`ifndef SCSEL_PARAMS_SVH
`define SCSEL_PARAMS_SVH

`define SCSEL_CTRL_OFS 4'h0
`define SCSEL_STAT_OFS 4'h4
`define SCSEL_CLK_SEL_LSB 0
`define SCSEL_XFER_FAST_BIT 3
`define SCSEL_WAIT_SEL_LSB 4
`define SCSEL_CTRL_RESET 8'h00
`define SCSEL_CLK_SEL_HIGH 3'h0
`define SCSEL_CLK_SEL_MAX 3'h5
`define SCSEL_CNT_W 24
`define SCSEL_CLK_MHZ 100
`define SCSEL_OSC_SETTLE_MS 8
`define SCSEL_EXT_SETTLE_US 500
`define SCSEL_EXT_SETTLE_CYC (`SCSEL_EXT_SETTLE_US * `SCSEL_CLK_MHZ)
`define SCSEL_OSC_SETTLE_CYC (`SCSEL_OSC_SETTLE_MS * 1000 * `SCSEL_CLK_MHZ)

`endif

// File: rtl/scsel_pkg.sv
// types shared by the clock/standby select block
`include "scsel_params.svh"
package scsel_pkg;

    typedef enum logic [1:0] {
        SCSEL_RUN,
        SCSEL_STANDBY,
        SCSEL_SETTLE
    } scsel_state_t;

    typedef struct packed {
        logic [2:0] clk_sel;
        logic xfer_fast;
        logic [2:0] wait_sel;
        logic ack;
        logic [31:0] rdata;
        scsel_state_t st;
        logic [`SCSEL_CNT_W-1:0] cnt;
        logic cpu_en;
        logic xfer_en;
        logic [1:0] wake_sync;
    } scsel_ctrl_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic tick;
    } scsel_div_t;

endpackage

// File: rtl/scsel_div_if.sv
// link between the select logic and the divider
`timescale 1ns/100ps
interface scsel_div_if;
    logic [2:0] sel;
    logic tick;
    modport ctrl (output sel, input tick);
    modport div (input sel, output tick);
endinterface

// File: rtl/scsel_div.sv
// free-running divider that makes the medium-speed enable tick
`timescale 1ns/100ps
module scsel_div (
    input wire logic clock,
    input wire logic rst,
    scsel_div_if.div dv
);
    scsel_pkg::scsel_div_t s_q;
    scsel_pkg::scsel_div_t s_d;
    logic [4:0] mask;

    always_comb
    begin
        case (dv.sel)
            3'h1: mask = 5'h01; // RL2
            3'h2: mask = 5'h03;
            3'h3: mask = 5'h07;
            3'h4: mask = 5'h0F;
            3'h5: mask = 5'h1F;
            default: mask = 5'h00; // RL1
        endcase
        s_d = s_q;
        s_d.cnt = s_q.cnt + 5'h01;
        // tick once every 2^sel cycles; code 0 ticks every cycle
        s_d.tick = ((s_q.cnt & mask) == mask);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign dv.tick = s_q.tick;
endmodule // scsel_div

// File: rtl/scsel_top.sv
// clock select and standby settling control for the bus masters
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "scsel_params.svh"
module scsel_top #(
    parameter int WAIT_BASE = `SCSEL_EXT_SETTLE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // standby control
    input wire logic standby_req,
    input wire logic wake_in,
    // transfer controller request
    input wire logic xfer_req,
    // bus master clock enables and standby status
    output logic cpu_clk_en,
    output logic xfer_clk_en,
    output logic standby_active
);
    scsel_pkg::scsel_ctrl_t s_q;
    scsel_pkg::scsel_ctrl_t s_d;
    logic req;
    logic wake;
    logic [7:0] ctrl_val;
    logic [7:0] stat_val;
    logic [`SCSEL_CNT_W-1:0] wait_base;
    logic [`SCSEL_CNT_W-1:0] wait_load;
    logic [2:0] new_sel;

    scsel_div_if dv ();

    scsel_div u_div (
        .clock(clock),
        .rst(rst),
        .dv(dv)
    );

    assign dv.sel = s_q.clk_sel;

    assign req = avs_read | avs_write;
    // answer one cycle after the request is seen, so read data is registered
    assign avs_waitrequest = req & ~s_q.ack;

    // only the second synchroniser stage is looked at
    assign wake = s_q.wake_sync[1];

    assign ctrl_val = {1'b0, s_q.wait_sel, s_q.xfer_fast, s_q.clk_sel};
    assign stat_val = {5'h00, (s_q.xfer_fast & xfer_req),
        (s_q.st == scsel_pkg::SCSEL_SETTLE), (s_q.st == scsel_pkg::SCSEL_STANDBY)};

    assign wait_base = `SCSEL_CNT_W'(WAIT_BASE);
    // each wait code doubles the settling time
    assign wait_load = `SCSEL_CNT_W'(wait_base << s_q.wait_sel) - `SCSEL_CNT_W'(1); // RL6

    assign new_sel = avs_writedata[`SCSEL_CLK_SEL_LSB +: 3];

    always_comb
    begin
        s_d = s_q;
        s_d.wake_sync = {s_q.wake_sync[0], wake_in};
        s_d.ack = req & ~s_q.ack;

        // register bus
        if (req && !s_q.ack)
        begin
            case (avs_address)
                `SCSEL_CTRL_OFS: s_d.rdata = {24'h000000, ctrl_val};
                `SCSEL_STAT_OFS: s_d.rdata = {24'h000000, stat_val};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        if (avs_write && s_q.ack && avs_address == `SCSEL_CTRL_OFS && avs_byteenable[0])
        begin
            // prohibited codes are dropped, keeping the old divider setting
            if (new_sel <= `SCSEL_CLK_SEL_MAX) // RL3
            begin
                s_d.clk_sel = new_sel; // RL2
            end
            s_d.xfer_fast = avs_writedata[`SCSEL_XFER_FAST_BIT];
            s_d.wait_sel = avs_writedata[`SCSEL_WAIT_SEL_LSB +: 3];
        end

        // standby sequencing
        case (s_q.st)
            scsel_pkg::SCSEL_RUN:
            begin
                if (standby_req)
                begin
                    s_d.st = scsel_pkg::SCSEL_STANDBY;
                end
            end
            scsel_pkg::SCSEL_STANDBY:
            begin
                if (wake)
                begin
                    s_d.st = scsel_pkg::SCSEL_SETTLE;
                    s_d.cnt = wait_load; // RL6
                end
            end
            scsel_pkg::SCSEL_SETTLE:
            begin
                if (s_q.cnt == '0)
                begin
                    s_d.st = scsel_pkg::SCSEL_RUN; // RL9
                end
                else
                begin
                    s_d.cnt = s_q.cnt - `SCSEL_CNT_W'(1); // RL9
                end
            end
            default:
            begin
                s_d.st = scsel_pkg::SCSEL_RUN;
            end
        endcase

        // masters get no enable outside the run state
        if (s_d.st == scsel_pkg::SCSEL_RUN && s_q.st == scsel_pkg::SCSEL_RUN)
        begin
            s_d.cpu_en = dv.tick; // RL1 RL2
            // in the divided modes, full rate for the transfer controller only while it is asking
            s_d.xfer_en = dv.tick | (s_q.xfer_fast & xfer_req); // RL4 RL5
        end
        else
        begin
            s_d.cpu_en = 1'b0; // RL9
            s_d.xfer_en = 1'b0; // RL9
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0; // RL1
            s_q.st <= scsel_pkg::SCSEL_RUN;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign cpu_clk_en = s_q.cpu_en;
    assign xfer_clk_en = s_q.xfer_en;
    assign standby_active = (s_q.st != scsel_pkg::SCSEL_RUN);
endmodule // scsel_top

// File: rtl/unused_placeholder_removed.sv
// intentionally empty compilation unit
`timescale 1ns/100ps

// File: bench/scsel_masters.sv
// bus master model: counts clock enables and holds a transfer request
`timescale 1ns/100ps
module scsel_masters (
    input wire logic clock,
    input wire logic rst,
    input wire logic cpu_clk_en,
    input wire logic xfer_clk_en,
    input wire logic xfer_go,
    output logic xfer_req,
    output logic [7:0] cpu_n,
    output logic [7:0] xfer_n
);
    always_ff @(posedge clock or posedge rst)
        if (rst)
            {xfer_req, cpu_n, xfer_n} <= 17'h0;
        else
        begin
            // a go pulse flips the request, so it stays steady between pulses
            xfer_req <= xfer_req ^ xfer_go;
            cpu_n <= cpu_n + 8'(cpu_clk_en);
            xfer_n <= xfer_n + 8'(xfer_clk_en);
        end
endmodule // scsel_masters

// File: bench/scsel_properties.sv
// port checks for clock select and standby exit
`timescale 1ns/100ps
module scsel_properties #(
    parameter int WAIT_BASE = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic wake_in,
    input wire logic xfer_req,
    input wire logic cpu_clk_en,
    input wire logic xfer_clk_en,
    input wire logic standby_active
);
    logic [6:0] sh_q;
    logic [7:0] r_q, g_q;
    // wide enough for the longest settle at wait code 7
    logic [9:0] w_q;
    logic wr;
    assign wr = avs_write && !avs_waitrequest && avs_address == 4'h0;
    always_ff @(posedge clock or posedge rst)
        if (rst)
            {sh_q, r_q, g_q, w_q} <= 33'h0;
        else
        begin
            // codes 11x are dropped, so the shadow keeps the old code
            if (wr)
                sh_q <= {avs_writedata[6:3], &avs_writedata[2:1] ? sh_q[2:0] : avs_writedata[2:0]};
            r_q <= standby_active || wr ? 8'h0 : r_q + 8'(r_q < 8'hFF);
            g_q <= cpu_clk_en ? 8'h0 : g_q + 8'h1;
            w_q <= standby_active && (wake_in || w_q > 10'h0) ? w_q + 10'h1 : 10'h0;
        end
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    a_full_speed: assert property (sh_q[2:0] == 3'h0 && r_q > 8'h3 |-> cpu_clk_en)
        else $error("speed");
    a_div_period: assert property (cpu_clk_en && sh_q[2:0] != 3'h0 && r_q > 8'h46
        |-> g_q == (8'h1 << sh_q[2:0]) - 8'h1) else $error("divide");
    a_shared_slow: assert property (!sh_q[3] && r_q > 8'h3
        |-> xfer_clk_en == cpu_clk_en) else $error("slow");
    a_fast_xfer: assert property (sh_q[3] && xfer_req && r_q > 8'h3
        |=> xfer_clk_en || standby_active) else $error("fast");
    a_masters_stopped: assert property (standby_active && $past(standby_active)
        || $fell(standby_active) |-> !cpu_clk_en && !xfer_clk_en) else $error("stop");
    a_settle_len: assert property ($fell(standby_active) |-> w_q inside
        {[(WAIT_BASE << sh_q[6:4]) + 2 : (WAIT_BASE << sh_q[6:4]) + 5]}) else $error("settle");
    c_exit: cover property ($fell(standby_active));
    c_fast: cover property (xfer_clk_en && !cpu_clk_en);
    c_slow: cover property (sh_q[2:0] == 3'h5 && cpu_clk_en);
endmodule // scsel_properties

// File: bench/system_clock_standby_select_tb_top.sv
// bench for the clock select and standby block
`timescale 1ns/100ps
module system_clock_standby_select_tb_top;
    logic clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, standby_req = 1'b0;
    logic wake_in = 1'b0, xfer_go = 1'b0, avs_waitrequest, xfer_req, cpu_clk_en, xfer_clk_en;
    logic standby_active;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [7:0] cpu_n, xfer_n, c0, lf = 8'h41;
    logic [2:0] ws;
    logic [31:0] q[$];
    int n_mismatch = 0, total_checks = 0, k;
    always #5 clock = ~clock;
    // settle base cut for run time; the default base alone meets the external clock floor
    scsel_top #(.WAIT_BASE(4)) DUT (.clock, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .standby_req,
        .wake_in, .xfer_req, .cpu_clk_en, .xfer_clk_en, .standby_active);
    scsel_masters masters (.clock, .rst, .cpu_clk_en, .xfer_clk_en, .xfer_go, .xfer_req,
        .cpu_n, .xfer_n);
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task report_and_stop;
        if (n_mismatch == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        if (!w)
            q.push_back({24'h0, e});
        k = 0;
        // request held until the rising edge that samples waitrequest low
        do
            @(posedge clock);
        while (avs_waitrequest !== 1'b0 && ++k < 9);
        n_mismatch += int'(k == 9);
        if (k == 9)
            report_and_stop;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    // a 32-cycle window is a whole number of periods for every divide code
    task win(input logic [7:0] ec, input logic [7:0] ex);
        repeat (40) @(negedge clock);
        c0 = cpu_n;
        k = int'(xfer_n);
        repeat (32) @(negedge clock);
        chk("ticks", {ec, ex}, {cpu_n - c0, xfer_n - 8'(k)});
        // hand back on a rising edge so the next stimulus starts there
        @(posedge clock);
    endtask
    always @(posedge clock)
        if (avs_read && avs_waitrequest === 1'b0)
            chk("avs_readdata", q.pop_front(), avs_readdata);
    initial
    begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, 4'h0, 8'h0, 8'h0);
        bus(1'b0, 4'h9, 8'h0, 8'h0);
        for (int c = 0; c < 6; c++)
        begin
            bus(1'b1, 4'h0, 8'(c), 8'h0);
            win(8'h20 >> c, 8'h20 >> c);
        end
        // software keeps to the legal clock codes
        bus(1'b1, 4'h0, 8'h0D, 8'h0);
        bus(1'b0, 4'h0, 8'h0, 8'h0D);
        lf = nxt(lf);
        // oscillator setting: wait code 4 and up is 16 bases or more
        ws = lf[6:4] | 3'h4;
        bus(1'b1, 4'h0, {1'b0, ws, 4'h3}, 8'h0);
        bus(1'b0, 4'h0, 8'h0, {1'b0, ws, 4'h3});
        xfer_go <= 1'b1;
        @(posedge clock);
        xfer_go <= 1'b0;
        win(8'h4, 8'h4);
        bus(1'b1, 4'h0, {1'b0, ws, 4'hB}, 8'h0);
        win(8'h4, 8'h20);
        standby_req <= 1'b1;
        @(posedge clock);
        standby_req <= 1'b0;
        win(8'h0, 8'h0);
        bus(1'b0, 4'h4, 8'h0, 8'h05);
        wake_in <= 1'b1;
        for (k = 0; k < 600 && standby_active !== 1'b0; k++)
            @(negedge clock);
        chk("settle", 1, k > (4 << ws) + 1 && k < (4 << ws) + 6);
        report_and_stop;
    end
endmodule // system_clock_standby_select_tb_top
bind scsel_top scsel_properties #(.WAIT_BASE(WAIT_BASE)) props (.clock, .rst, .avs_address,
    .avs_write, .avs_writedata, .avs_waitrequest, .wake_in, .xfer_req, .cpu_clk_en,
    .xfer_clk_en, .standby_active);
